// ### core/iodbs_pkg.sv
// constants for the i/o decode and bus status glue block
package iodbs_pkg;
   // ==========================================
   // clock derivation
   localparam int XTAL_MHZ = 16;
   localparam int REF_CLK_MHZ = 200;
   localparam int DIV_WIDTH = 3;
   localparam int PHASE2_BIT = 1;
   localparam int CLOCK2M_BIT = 2;
   localparam int PHASE2_MHZ = XTAL_MHZ / (1 << (PHASE2_BIT + 1));
   localparam int CLOCK2M_MHZ = XTAL_MHZ / (1 << (CLOCK2M_BIT + 1));
   localparam logic [DIV_WIDTH-1:0] DIV_RESET = 3'h0;
   localparam logic [1:0] PHASE2_PRE_RISE = 2'h1;

   // ==========================================
   // port address layout
   localparam int ADDR_WIDTH = 8;
   localparam int BLOCK_MSB = 7;
   localparam int BLOCK_LSB = 5;
   localparam int GROUP_MSB = 4;
   localparam int GROUP_LSB = 2;
   localparam int CTRL_DATA_BIT = 1;
   localparam int CHANNEL_BIT = 0;
   localparam int GROUP_COUNT = 8;
   localparam int PERIPH_COUNT = 4;

   // ==========================================
   // reset values
   localparam logic [GROUP_COUNT-1:0] SEL_IDLE = 8'hFF;
   localparam logic [GROUP_COUNT-1:0] SEL_ONE = 8'h01;
   localparam logic [PERIPH_COUNT-1:0] PRIO_ALL_HIGH = 4'hF;
   localparam logic [PERIPH_COUNT-1:0] CE_IDLE = 4'hF;
   localparam logic [6:0] STAT_RESET = 7'h01;
   localparam logic [6:0] CTL_RESET = 7'h16;
   localparam logic LOW_ACTIVE_IDLE = 1'b1;
   localparam logic HIGH_ACTIVE_IDLE = 1'b0;
   localparam logic OPEN_DRAIN_LEVEL = 1'b0;
endpackage

// ### core/iodbs_binary_counter.sv
// free binary counter advanced by a count strobe
module iodbs_binary_counter
   import iodbs_pkg::*;
#(
   parameter int WIDTH = DIV_WIDTH
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // count control
   input wire logic countStrobe,
   output logic [WIDTH-1:0] count
);
   // ==========================================
   // counter
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;

   always_comb begin
      count_next = count_reg;
      if (countStrobe) begin
         count_next = count_reg + WIDTH'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= '0;
      end else if (clk_en) begin
         count_reg <= count_next;
      end
   end

   assign count = count_reg;
endmodule

// ### core/iodbs_io_decode_bus_status.sv
// port address decoder, bus status/control outputs and bus clocks
//
// What this block does
// - decode only on matching header bits plus request
// - ports live in one aligned 32-port block
// - one of eight low selects from bits 4-2
// - each chip enable strapped to any group
// - bit 0 picks channel, bit 1 control/data
// - dma group ignores the two low bits
// - write status follows either write strobe
// - halt status follows processor halt
// - sync one clock when both requests idle
// - data-in on read, or clean interrupt acknowledge
// - bus refresh follows processor refresh
// - hold acknowledge follows dma grant chain out
// - any low priority output pulls interrupt lines
// - 2 MHz reference on bus clock line
// - 4 MHz master timing on phase-2 line
// - bus clocks from crystal via binary counter
module iodbs_io_decode_bus_status
   import iodbs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // crystal oscillator level
   input wire logic xtal16,
   // processor and dma strobes
   input wire logic [ADDR_WIDTH-1:0] addr,
   input wire logic memory_request_n,
   input wire logic io_request_n,
   input wire logic op_fetch_n,
   input wire logic cpu_read_n,
   input wire logic cpu_write_n,
   input wire logic dma_read_n,
   input wire logic dma_write_n,
   input wire logic cpu_halt_n,
   input wire logic refresh_cycle_n,
   input wire logic bus_grant_chain_out_n,
   input wire logic [PERIPH_COUNT-1:0] priority_enable_out,
   // straps
   input wire logic [2:0] address_select_header,
   input wire logic [2:0] timer_group,
   input wire logic [2:0] dma_group,
   input wire logic [2:0] serial_group,
   input wire logic [2:0] parallel_group,
   input wire logic mem_req_enable,
   // peripheral selects
   output logic [GROUP_COUNT-1:0] group_select_n,
   output logic timer_ce_n,
   output logic dma_ce_n,
   output logic serial_ce_n,
   output logic parallel_ce_n,
   output logic serial_chan_b,
   output logic serial_ctrl,
   output logic offboard_port,
   // bus status
   output logic status_write_n,
   output logic status_int_ack,
   output logic status_op_fetch,
   output logic status_halt_ack,
   output logic status_mem_read,
   output logic status_out,
   output logic status_inp,
   // bus control
   output logic bus_sync,
   output logic bus_data_in,
   output logic bus_write_n,
   output logic bus_mem_req_n,
   output logic bus_mem_write,
   output logic bus_refresh_n,
   output logic bus_hold_ack,
   // open-drain interrupt lines
   output logic bus_int_req_o,
   output logic bus_int_req_oe,
   output logic bus_vi0_o,
   output logic bus_vi0_oe,
   // bus clocks
   output logic bus_clock_2m,
   output logic bus_phase2
);
   // ==========================================
   // clock derivation
   logic xtalPrev_reg;
   logic xtalPrev_next;
   logic sync_reg;
   logic sync_next;
   logic xtalRise;
   logic phase2Rise;
   logic [DIV_WIDTH-1:0] divCount;

   assign xtalRise = xtal16 & ~xtalPrev_reg;
   // phase-2 rises when bit 1 turns from 0 to 1
   assign phase2Rise = xtalRise && (divCount[1:0] == PHASE2_PRE_RISE);

   iodbs_binary_counter #(
      .WIDTH(DIV_WIDTH)
   ) u_div (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .countStrobe(xtalRise),
      .count(divCount)
   );

   always_comb begin
      xtalPrev_next = xtal16;
      sync_next = sync_reg;
      if (phase2Rise) begin
         sync_next = memory_request_n & io_request_n;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         xtalPrev_reg <= HIGH_ACTIVE_IDLE;
         sync_reg <= HIGH_ACTIVE_IDLE;
      end else if (clk_en) begin
         xtalPrev_reg <= xtalPrev_next;
         sync_reg <= sync_next;
      end
   end

   assign bus_phase2 = divCount[PHASE2_BIT];
   assign bus_clock_2m = divCount[CLOCK2M_BIT];
   assign bus_sync = sync_reg;

   // ==========================================
   // port address decoder
   logic blockHit;
   logic [2:0] groupIndex;
   logic groupOccupied;
   logic [GROUP_COUNT-1:0] sel_reg;
   logic [GROUP_COUNT-1:0] sel_next;
   logic [PERIPH_COUNT-1:0] ce_reg;
   logic [PERIPH_COUNT-1:0] ce_next;
   logic chanB_reg;
   logic chanB_next;
   logic ctrl_reg;
   logic ctrl_next;
   logic offboard_reg;
   logic offboard_next;

   // block base has its five low bits zero
   assign blockHit = !io_request_n &&
      (addr[BLOCK_MSB:BLOCK_LSB] == address_select_header);
   assign groupIndex = addr[GROUP_MSB:GROUP_LSB];
   assign groupOccupied = (groupIndex == timer_group) || (groupIndex == dma_group) ||
      (groupIndex == serial_group) || (groupIndex == parallel_group);

   always_comb begin
      sel_next = SEL_IDLE;
      if (blockHit) begin
         sel_next = ~(SEL_ONE << groupIndex);
      end
      // the dma sees no low address bits, so all four ports alias
      ce_next[0] = sel_next[timer_group];
      ce_next[1] = sel_next[dma_group];
      ce_next[2] = sel_next[serial_group];
      ce_next[3] = sel_next[parallel_group];
      chanB_next = addr[CHANNEL_BIT];
      ctrl_next = addr[CTRL_DATA_BIT];
      offboard_next = blockHit && !groupOccupied;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_reg <= SEL_IDLE;
         ce_reg <= CE_IDLE;
         chanB_reg <= HIGH_ACTIVE_IDLE;
         ctrl_reg <= HIGH_ACTIVE_IDLE;
         offboard_reg <= HIGH_ACTIVE_IDLE;
      end else if (clk_en) begin
         sel_reg <= sel_next;
         ce_reg <= ce_next;
         chanB_reg <= chanB_next;
         ctrl_reg <= ctrl_next;
         offboard_reg <= offboard_next;
      end
   end

   assign group_select_n = sel_reg;
   assign timer_ce_n = ce_reg[0];
   assign dma_ce_n = ce_reg[1];
   assign serial_ce_n = ce_reg[2];
   assign parallel_ce_n = ce_reg[3];
   assign serial_chan_b = chanB_reg;
   assign serial_ctrl = ctrl_reg;
   assign offboard_port = offboard_reg;

   // ==========================================
   // bus status and control
   logic writeAct;
   logic readAct;
   logic intAck;
   logic anyPrioLow;
   logic [6:0] stat_reg;
   logic [6:0] stat_next;
   logic [6:0] ctl_reg;
   logic [6:0] ctl_next;

   assign writeAct = !cpu_write_n || !dma_write_n;
   assign readAct = !cpu_read_n || !dma_read_n;
   assign intAck = !op_fetch_n && !io_request_n;
   assign anyPrioLow = (priority_enable_out != PRIO_ALL_HIGH);

   always_comb begin
      stat_next[0] = !writeAct;
      stat_next[1] = intAck;
      stat_next[2] = !op_fetch_n;
      stat_next[3] = !cpu_halt_n;
      stat_next[4] = !memory_request_n && readAct;
      stat_next[5] = !io_request_n && writeAct;
      stat_next[6] = !io_request_n && readAct;
      ctl_next[0] = readAct || (intAck && !anyPrioLow);
      ctl_next[1] = !writeAct;
      ctl_next[2] = !(!memory_request_n && mem_req_enable);
      ctl_next[3] = writeAct && stat_next[5];
      ctl_next[4] = refresh_cycle_n;
      ctl_next[5] = !bus_grant_chain_out_n;
      ctl_next[6] = anyPrioLow;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_reg <= STAT_RESET;
         ctl_reg <= CTL_RESET;
      end else if (clk_en) begin
         stat_reg <= stat_next;
         ctl_reg <= ctl_next;
      end
   end

   assign status_write_n = stat_reg[0];
   assign status_int_ack = stat_reg[1];
   assign status_op_fetch = stat_reg[2];
   assign status_halt_ack = stat_reg[3];
   assign status_mem_read = stat_reg[4];
   assign status_out = stat_reg[5];
   assign status_inp = stat_reg[6];
   assign bus_data_in = ctl_reg[0];
   assign bus_write_n = ctl_reg[1];
   assign bus_mem_req_n = ctl_reg[2];
   assign bus_mem_write = ctl_reg[3];
   assign bus_refresh_n = ctl_reg[4];
   assign bus_hold_ack = ctl_reg[5];
   assign bus_int_req_o = OPEN_DRAIN_LEVEL;
   assign bus_vi0_o = OPEN_DRAIN_LEVEL;
   assign bus_int_req_oe = ctl_reg[6];
   assign bus_vi0_oe = ctl_reg[6];

   // ==========================================
   // assertions
   decode_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && (io_request_n || addr[7:5] != address_select_header)
      |=> group_select_n == SEL_IDLE)
      else $error("group select active without block hit");

   decode_one_hot_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && blockHit |=> group_select_n == ~(SEL_ONE << $past(groupIndex)))
      else $error("wrong group select for address");

   strap_ce_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && blockHit && groupIndex == serial_group |=> !serial_ce_n)
      else $error("serial enable missed its strapped group");

   dma_alias_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en ##1 clk_en && $stable(addr[7:2]) && $stable(io_request_n) && $stable(dma_group)
      && $stable(address_select_header) |=> $stable(dma_ce_n))
      else $error("dma enable depends on low address bits");

   write_status_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && (!cpu_write_n || !dma_write_n) |=> !status_write_n && !bus_write_n)
      else $error("write status missing");

   sync_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && phase2Rise && memory_request_n && io_request_n |=> bus_sync)
      else $error("sync not raised at idle phase-2 edge");

   data_in_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && intAck && anyPrioLow && cpu_read_n && dma_read_n |=> !bus_data_in)
      else $error("data-in raised while on-board acknowledge pending");

   int_chain_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && anyPrioLow |=> bus_int_req_oe && bus_vi0_oe)
      else $error("interrupt lines not pulled low");

   mem_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && !io_request_n && !cpu_write_n |=> bus_mem_write && status_out)
      else $error("memory write strobe missing");

   clock_ratio_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && phase2Rise |=> bus_phase2 && $past(bus_phase2) == 1'b0)
      else $error("phase-2 did not rise on divider edge");

   sync_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(bus_sync));
   io_decode_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(timer_ce_n));
   int_ack_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      status_int_ack && bus_data_in);
   offboard_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(offboard_port));
endmodule

// ### tb/iodbs_backplane.sv
// backplane model: pulled-up interrupt lines and an off-board port board
module iodbs_backplane (
   // open-drain drivers from the card
   input wire logic intReqO,
   input wire logic intReqOe,
   input wire logic vi0O,
   input wire logic vi0Oe,
   // decode hint seen by off-board port boards
   input wire logic offboardPort,
   // resolved bus levels
   output logic intReqLine,
   output logic vi0Line,
   output logic portClaim
);
   timeunit 1ns;
   timeprecision 100ps;
   // released lines float to the pull-up level
   assign intReqLine = intReqOe ? intReqO : 1'b1;
   assign vi0Line = vi0Oe ? vi0O : 1'b1;
   // off-board boards answer only where no on-board group sits
   assign portClaim = offboardPort;
endmodule

// ### tb/iodbs_io_decode_bus_status_tb.sv
// self-checking bench for the i/o decode and bus status block
module iodbs_io_decode_bus_status_tb
   import iodbs_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 0, rst_n = 0, clkEn = 0, xtal = 0, memReqEn = 0;
   logic [7:0] addr = 0;
   logic memReqN = 1, ioReqN = 1, fetchN = 1, crdN = 1, cwrN = 1, drdN = 1, dwrN = 1;
   logic haltN = 1, refreshN = 1, grantN = 1;
   logic [3:0] prio = 4'hF;
   logic [2:0] hdr = 0, tg = 0, dg = 1, sg = 2, pg = 3;
   logic [7:0] gsel;
   logic tce, dce, sce, pce, chB, ctl, offb, swN, sIa, sFetch, sHa, sMr, sOut, sInp;
   logic sync, dbin, wrN, bmrN, mwr, rfN, hlda, iro, iroe, vio, vioe, c2m, ph2;
   logic intLine, viLine, claim;
   // reference model state
   logic [7:0] eG;
   logic [3:0] eCe;
   logic [1:0] eSc;
   logic [6:0] eSt, eBc;
   logic [2:0] cnt;
   logic eOff, prevX, eSync;
   logic [31:0] r;
   int seed = 20, xc = 0, cycles = 0, miscompares = 0, samples_checked = 0;

   always #2.5 ref_clk = ~ref_clk;

   iodbs_io_decode_bus_status iodbs_io_decode_bus_status_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .clk_en(clkEn), .xtal16(xtal), .addr(addr), .memory_request_n(memReqN),
      .io_request_n(ioReqN), .op_fetch_n(fetchN), .cpu_read_n(crdN), .cpu_write_n(cwrN),
      .dma_read_n(drdN), .dma_write_n(dwrN), .cpu_halt_n(haltN), .refresh_cycle_n(refreshN),
      .bus_grant_chain_out_n(grantN), .priority_enable_out(prio), .address_select_header(hdr),
      .timer_group(tg), .dma_group(dg), .serial_group(sg), .parallel_group(pg),
      .mem_req_enable(memReqEn), .group_select_n(gsel), .timer_ce_n(tce), .dma_ce_n(dce),
      .serial_ce_n(sce), .parallel_ce_n(pce), .serial_chan_b(chB), .serial_ctrl(ctl),
      .offboard_port(offb), .status_write_n(swN), .status_int_ack(sIa),
      .status_op_fetch(sFetch), .status_halt_ack(sHa), .status_mem_read(sMr),
      .status_out(sOut), .status_inp(sInp), .bus_sync(sync), .bus_data_in(dbin),
      .bus_write_n(wrN), .bus_mem_req_n(bmrN), .bus_mem_write(mwr), .bus_refresh_n(rfN),
      .bus_hold_ack(hlda), .bus_int_req_o(iro), .bus_int_req_oe(iroe), .bus_vi0_o(vio),
      .bus_vi0_oe(vioe), .bus_clock_2m(c2m), .bus_phase2(ph2));

   iodbs_backplane iodbs_backplane_i (.intReqO(iro), .intReqOe(iroe), .vi0O(vio),
      .vi0Oe(vioe), .offboardPort(offb), .intReqLine(intLine), .vi0Line(viLine),
      .portClaim(claim));

   task automatic close_out();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(logic [7:0] seen, logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rst_model();
      eG = SEL_IDLE;
      eCe = 4'hF;
      eSc = 2'h0;
      eOff = 0;
      eSt = 7'h40;
      eBc = 7'h34;
      cnt = DIV_RESET;
      prevX = 0;
      eSync = 0;
   endtask

   task automatic step();
      logic hit, rd, wr, io;
      io = !ioReqN;
      hit = addr[7:5] == hdr && io;
      rd = !crdN || !drdN;
      wr = !cwrN || !dwrN;
      eG = hit ? ~(SEL_ONE << addr[4:2]) : SEL_IDLE;
      eCe = {eG[tg], eG[dg], eG[sg], eG[pg]};
      eSc = addr[1:0];
      eOff = hit && addr[4:2] != tg && addr[4:2] != dg && addr[4:2] != sg && addr[4:2] != pg;
      eSt = {!wr, !fetchN && io, !fetchN, !haltN, !memReqN && rd, io && wr, io && rd};
      eBc = {rd || (!fetchN && io && &prio), !wr, !(!memReqN && memReqEn), wr && io,
         refreshN, !grantN, !(&prio)};
      if (xtal && !prevX) begin
         if (cnt[1:0] == 2'h1) eSync = memReqN && ioReqN;
         cnt = cnt + 3'h1;
      end
      prevX = xtal;
   endtask

   task automatic compare();
      check(gsel, eG);
      check({tce, dce, sce, pce}, eCe);
      check({ctl, chB}, eSc);
      check({offb, claim}, {eOff, eOff});
      check({swN, sIa, sFetch, sHa, sMr, sOut, sInp}, eSt);
      check({dbin, wrN, bmrN, mwr, rfN, hlda, iroe}, eBc);
      check({iro, vio, vioe, intLine, viLine}, {2'h0, eBc[0], ~eBc[0], ~eBc[0]});
      check({c2m, ph2}, cnt[2:1]);
      check(sync, eSync);
   endtask

   task automatic drive();
      r = $random(seed);
      addr = r[8] ? {hdr, r[4:0]} : r[7:0];
      {memReqN, ioReqN, fetchN, crdN, cwrN, drdN, dwrN} = r[15:9];
      {haltN, refreshN, grantN, memReqEn} = r[19:16];
      prio = r[23:20] | {4{r[24]}};
      clkEn = r[27:25] != 3'h0;
      if (r[31:28] == 4'h0) begin
         r = $random(seed);
         {hdr, tg, dg, sg, pg} = r[14:0];
      end
      xc++;
      if (xc == 6) begin
         xc = 0;
         xtal = ~xtal;
      end
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         close_out();
      end
   end

   initial begin
      rst_model();
      repeat (10) @(posedge ref_clk);
      #1;
      compare();
      rst_n = 1;
      for (int i = 0; i < 3000; i++) begin
         @(posedge ref_clk);
         if (rst_n && clkEn) step();
         #1;
         compare();
         if (i == 1500) begin
            rst_n = 0;
            xtal = 0;
            xc = 0;
            rst_model();
            #1;
            compare();
            repeat (2) @(posedge ref_clk);
            #1;
            rst_n = 1;
         end else begin
            drive();
         end
      end
      close_out();
   end
endmodule
